// file: src/smbrc_client.sv
// smbrc_client: smbus / i2c client that reads and writes the device registers
// assumes an open-drain data pin resolved outside and a register file on clk_i
`timescale 1ns/1ps
`default_nettype none

module smbrc_client #(
   parameter int unsigned LOW_CYC  = smbrc_pkg::LOW_CYC,    // clock-low time-out in cycles
   parameter int unsigned IDLE_CYC = smbrc_pkg::IDLE_CYC    // idle reset in cycles
) (
   input  wire logic                      clk_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      bus_clock_line_i,
   input  wire logic                      sda_i,
   output var  logic                      sda_o,
   output var  logic                      sda_oe_o,
   input  wire logic                      timeout_disable_i,
   input  wire logic                      sleep_i,
   input  wire logic [7:0]                reg_rdata_i,
   output var  smbrc_pkg::smbrc_reg_req_t reg_req_o,
   output var  logic                      busy_o
);

   // ---------------------------------------------------------------
   // link domain: bit capture on the host clock
   // ---------------------------------------------------------------
   logic link_bit = 1'b0;                           // data sampled at the last rising edge
   logic link_tgl = 1'b0;                           // flips once per rising edge
   logic next_link_bit;
   logic next_link_tgl;

   // the host clock may stop between frames; nothing here needs a later edge
   always_comb begin
      next_link_bit = sda_i;
      next_link_tgl = ~link_tgl;
   end

   always_ff @(posedge bus_clock_line_i) begin
      link_bit <= next_link_bit;
      link_tgl <= next_link_tgl;
   end

   // ---------------------------------------------------------------
   // crossing and line filtering
   // ---------------------------------------------------------------
   logic [2:0] s2;                                  // {tgl, sda, scl} second stage
   logic [2:0] s3;                                  // {tgl, sda, scl} third stage
   logic [2:0] filt;                                // agreed levels
   logic [2:0] filt_q;                              // agreed levels one cycle back
   logic [2:0] next_filt;
   logic [2:0] next_filt_q;

   smbrc_sync u_sync (
      .clk_i (clk_i),
      .d_i   ({link_tgl, sda_i, bus_clock_line_i}),
      .s2_o  (s2),
      .s3_o  (s3)
   );

   // a change counts only once stages two and three agree
   always_comb begin
      next_filt_q = filt;
      for (int i = 0; i < 3; i++) begin
         next_filt[i] = (s2[i] == s3[i]) ? s3[i] : filt[i];
      end
      if (!rst_n_i) begin
         next_filt   = s3;                          // track silently, no events from reset
         next_filt_q = s3;
      end
   end

   always_ff @(posedge clk_i) begin
      filt   <= next_filt;
      filt_q <= next_filt_q;
   end

   logic scl_f;                                     // filtered clock line
   logic sda_f;                                     // filtered data line
   logic start_ev;                                  // start or repeated start
   logic stop_ev;                                   // stop
   logic scl_fall;                                  // clock line fell
   logic bit_ev;                                    // a new bit sits in link_bit
   logic [7:0] byte_in;                             // shifter with the new bit appended

   assign scl_f    = filt[0];
   assign sda_f    = filt[1];
   assign start_ev = scl_f && filt_q[0] && filt_q[1] && !sda_f;
   assign stop_ev  = scl_f && filt_q[0] && !filt_q[1] && sda_f;
   assign scl_fall = filt_q[0] && !scl_f;
   assign bit_ev   = filt[2] != filt_q[2];

   // ---------------------------------------------------------------
   // bus time-outs
   // ---------------------------------------------------------------
   logic [smbrc_pkg::LOW_W-1:0]  low_cnt;           // cycles with clock low
   logic [smbrc_pkg::IDLE_W-1:0] idle_cnt;          // cycles with both lines high
   logic [smbrc_pkg::LOW_W-1:0]  next_low_cnt;
   logic [smbrc_pkg::IDLE_W-1:0] next_idle_cnt;
   logic                         proto_rst;         // one-cycle protocol reset
   logic                         next_proto_rst;

   // counters held at zero while the disable input is high
   always_comb begin
      next_low_cnt   = '0;
      next_idle_cnt  = '0;
      next_proto_rst = 1'b0;
      if (!timeout_disable_i && !scl_f) begin
         next_low_cnt = low_cnt + 1'b1;
         if (low_cnt == smbrc_pkg::LOW_W'(LOW_CYC - 1)) begin
            next_proto_rst = 1'b1;
            next_low_cnt   = '0;
         end
      end
      if (!timeout_disable_i && !sleep_i && scl_f && sda_f) begin
         next_idle_cnt = idle_cnt + 1'b1;
         if (idle_cnt == smbrc_pkg::IDLE_W'(IDLE_CYC - 1)) begin
            next_proto_rst = 1'b1;
            next_idle_cnt  = '0;
         end
      end
      if (!rst_n_i) begin
         next_low_cnt   = '0;
         next_idle_cnt  = '0;
         next_proto_rst = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      low_cnt   <= next_low_cnt;
      idle_cnt  <= next_idle_cnt;
      proto_rst <= next_proto_rst;
   end

   // ---------------------------------------------------------------
   // protocol engine
   // ---------------------------------------------------------------
   smbrc_pkg::smbrc_state_t   state;                // where in the frame we are
   smbrc_pkg::smbrc_phase_t   phase;                // meaning of the next received byte
   logic [2:0]                bit_cnt;              // bit within the byte
   logic [7:0]                shreg;                // received bits
   logic [7:0]                tx;                   // byte being sent
   logic                      rw;                   // direction of this phase
   logic [7:0]                ptr;                  // internal register pointer
   logic                      ptr_only;             // pointer set, no data yet
   logic                      send_flag;            // last frame was pointer-only
   smbrc_pkg::smbrc_state_t   next_state;
   smbrc_pkg::smbrc_phase_t   next_phase;
   logic [2:0]                next_bit_cnt;
   logic [7:0]                next_shreg;
   logic [7:0]                next_tx;
   logic                      next_rw;
   logic [7:0]                next_ptr;
   logic                      next_ptr_only;
   logic                      next_send_flag;
   logic                      next_oe;
   logic                      next_busy;
   smbrc_pkg::smbrc_reg_req_t next_req;

   assign byte_in = {shreg[6:0], link_bit};

   // clock line is never driven: the host may stretch it under LOW_CYC cycles, without limit only while timeout_disable_i is high
   always_comb begin
      next_state     = state;
      next_phase     = phase;
      next_bit_cnt   = bit_cnt;
      next_shreg     = shreg;
      next_tx        = tx;
      next_rw        = rw;
      next_ptr       = ptr;
      next_ptr_only  = ptr_only;
      next_send_flag = send_flag;
      next_oe        = sda_oe_o;
      next_busy      = (state != smbrc_pkg::S_IDLE);
      next_req       = reg_req_o;
      next_req.addr  = ptr;
      next_req.wr    = 1'b0;
      next_req.rd    = 1'b0;
      // a start that lands in the idle expiry cycle still wins, or it would be lost
      if (proto_rst && !start_ev) begin
         next_state    = smbrc_pkg::S_IDLE;         // back to waiting for a start
         next_oe       = 1'b0;
         next_ptr_only = 1'b0;                      // a cut frame is no send byte
      end else if (stop_ev) begin
         next_state = smbrc_pkg::S_IDLE;
         next_oe    = 1'b0;
         if (ptr_only) begin
            next_send_flag = 1'b1;
         end
         next_ptr_only = 1'b0;
      end else if (start_ev) begin
         next_state    = smbrc_pkg::S_RX;
         next_phase    = smbrc_pkg::PH_ADDR;
         next_bit_cnt  = '0;
         next_oe       = 1'b0;
         next_ptr_only = 1'b0;
      end else begin
         case (state)
            smbrc_pkg::S_RX: begin
               if (bit_ev) begin
                  next_shreg   = byte_in;
                  next_bit_cnt = bit_cnt + 1'b1;
                  if (bit_cnt == smbrc_pkg::LAST_BIT) begin
                     case (phase)
                        smbrc_pkg::PH_ADDR: begin
                           if (byte_in[7:1] == smbrc_pkg::CLIENT_ADDR) begin
                              next_rw    = byte_in[0];
                              next_state = smbrc_pkg::S_ACKW;
                              next_phase = smbrc_pkg::PH_PTR;
                              if (byte_in[0] == smbrc_pkg::RW_READ) begin
                                 next_send_flag = 1'b0;
                              end
                           end else begin
                              next_state = smbrc_pkg::S_IDLE;
                           end
                        end
                        smbrc_pkg::PH_PTR: begin
                           if (send_flag) begin
                              next_send_flag = 1'b0;
                              next_state     = smbrc_pkg::S_IDLE;
                           end else begin
                              next_ptr      = byte_in;
                              next_ptr_only = 1'b1;
                              next_phase    = smbrc_pkg::PH_DATA;
                              next_state    = smbrc_pkg::S_ACKW;
                           end
                        end
                        default: begin
                           // data byte: store, then move on
                           next_req.wr    = 1'b1;
                           next_req.wdata = byte_in;
                           next_ptr       = ptr + 1'b1;
                           next_ptr_only  = 1'b0;
                           next_send_flag = 1'b0;
                           next_state     = smbrc_pkg::S_ACKW;
                        end
                     endcase
                  end
               end
            end
            smbrc_pkg::S_ACKW: begin
               if (scl_fall) begin
                  next_oe    = 1'b1;                // pull data low for the ninth clock
                  next_state = smbrc_pkg::S_ACK;
               end
            end
            smbrc_pkg::S_ACK, smbrc_pkg::S_LOAD: begin
               if (scl_fall) begin
                  if (state == smbrc_pkg::S_LOAD || rw == smbrc_pkg::RW_READ) begin
                     next_tx      = reg_rdata_i;
                     next_oe      = ~reg_rdata_i[7];
                     next_req.rd  = 1'b1;
                     next_bit_cnt = '0;
                     next_state   = smbrc_pkg::S_TX;
                  end else begin
                     next_oe      = 1'b0;
                     next_bit_cnt = '0;
                     next_state   = smbrc_pkg::S_RX;
                  end
               end
            end
            smbrc_pkg::S_TX: begin
               if (scl_fall) begin
                  if (bit_cnt == smbrc_pkg::LAST_BIT) begin
                     next_oe    = 1'b0;             // release for the host's answer
                     next_state = smbrc_pkg::S_MACK;
                  end else begin
                     next_tx      = {tx[6:0], 1'b0};
                     next_oe      = ~tx[6];
                     next_bit_cnt = bit_cnt + 1'b1;
                  end
               end
            end
            smbrc_pkg::S_MACK: begin
               if (bit_ev) begin
                  if (!link_bit) begin
                     next_ptr   = ptr + 1'b1;       // host wants more
                     next_state = smbrc_pkg::S_LOAD;
                  end else begin
                     next_state = smbrc_pkg::S_IDLE;  // last byte, wait for stop
                  end
               end
            end
            default: begin
               next_oe = 1'b0;                      // idle: line released
            end
         endcase
      end
      if (!rst_n_i) begin
         next_state     = smbrc_pkg::S_IDLE;
         next_phase     = smbrc_pkg::PH_ADDR;
         next_bit_cnt   = '0;
         next_shreg     = '0;
         next_tx        = '0;
         next_rw        = 1'b0;
         next_ptr       = '0;
         next_ptr_only  = 1'b0;
         next_send_flag = 1'b0;
         next_oe        = 1'b0;
         next_busy      = 1'b0;
         next_req       = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      state     <= next_state;
      phase     <= next_phase;
      bit_cnt   <= next_bit_cnt;
      shreg     <= next_shreg;
      tx        <= next_tx;
      rw        <= next_rw;
      ptr       <= next_ptr;
      ptr_only  <= next_ptr_only;
      send_flag <= next_send_flag;
      sda_oe_o  <= next_oe;
      sda_o     <= 1'b0;                            // open drain: only ever pulls low
      busy_o    <= next_busy;
      reg_req_o <= next_req;
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_eighth_bit;
      state == smbrc_pkg::S_RX && bit_ev && bit_cnt == 3'h7 && !proto_rst && !stop_ev && !start_ev;
   endsequence

   property p_start;
      start_ev |=> state == smbrc_pkg::S_RX && phase == smbrc_pkg::PH_ADDR && bit_cnt == 3'h0;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");

   property p_foreign;
      s_eighth_bit and (phase == smbrc_pkg::PH_ADDR && byte_in[7:1] != 7'h57)
         |=> state == smbrc_pkg::S_IDLE [*2] ##0 !sda_oe_o;
   endproperty
   a_foreign: assert property (p_foreign) else $error("foreign address answered");

   property p_ack;
      state == smbrc_pkg::S_ACKW && scl_fall && !proto_rst && !stop_ev && !start_ev
         |=> sda_oe_o && state == smbrc_pkg::S_ACK;
   endproperty
   a_ack: assert property (p_ack) else $error("acknowledge not driven");

   property p_stop;
      stop_ev |=> state == smbrc_pkg::S_IDLE && !sda_oe_o;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not reset client");

   property p_low_to;
      proto_rst |-> $past(low_cnt) == smbrc_pkg::LOW_W'(LOW_CYC - 1) || $past(idle_cnt) == smbrc_pkg::IDLE_W'(IDLE_CYC - 1);
   endproperty
   a_low_to: assert property (p_low_to) else $error("protocol reset without expiry");

   property p_disabled;
      timeout_disable_i [*2] |-> low_cnt == '0 && idle_cnt == '0 && !proto_rst;
   endproperty
   a_disabled: assert property (p_disabled) else $error("time-out ran while disabled");

   property p_tx_end;
      state == smbrc_pkg::S_TX && scl_fall && bit_cnt == 3'h7 && !proto_rst && !stop_ev && !start_ev
         |=> !sda_oe_o && state == smbrc_pkg::S_MACK;
   endproperty
   a_tx_end: assert property (p_tx_end) else $error("line held after eighth bit");

   property p_wr_ptr;
      reg_req_o.wr |-> ptr == 8'(reg_req_o.addr + 8'h01);
   endproperty
   a_wr_ptr: assert property (p_wr_ptr) else $error("pointer did not advance");

   property p_write;
      s_eighth_bit and (phase == smbrc_pkg::PH_DATA)
         |=> reg_req_o.wr && reg_req_o.wdata == $past(byte_in) && state == smbrc_pkg::S_ACKW;
   endproperty
   a_write: assert property (p_write) else $error("data byte not stored");

   property p_second_send;
      s_eighth_bit and (phase == smbrc_pkg::PH_PTR && send_flag)
         |=> state == smbrc_pkg::S_IDLE && ptr == $past(ptr) && !send_flag;
   endproperty
   a_second_send: assert property (p_second_send) else $error("second pointer write taken");

endmodule // smbrc_client

`default_nettype wire

// file: src/smbrc_pkg.sv
// smbrc_pkg: constants, states and carriers of the smbus register client
// assumes a 100 MHz system clock and a host clock between 10 and 400 kHz
`default_nettype none

package smbrc_pkg;

   // ---------------------------------------------------------------
   // bus identity and framing
   // ---------------------------------------------------------------
   localparam logic [6:0] CLIENT_ADDR = 7'h57;      // fixed client address, 1010 111
   localparam int         BYTE_BITS   = 8;          // bits per byte, msb first
   localparam logic [2:0] LAST_BIT    = 3'h7;       // bit counter value of the eighth bit
   localparam logic       RW_WRITE    = 1'b0;       // direction bit: host writes
   localparam logic       RW_READ     = 1'b1;       // direction bit: host reads

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;               // system clock period
   localparam int TIMEOUT_MS    = 30;               // clock-low time-out
   localparam int IDLE_US       = 200;              // both-lines-high idle reset
   localparam int LOW_CYC       = (TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
   localparam int IDLE_CYC      = (IDLE_US * 1000) / CLK_PERIOD_NS;
   localparam int LOW_W         = 22;               // wide enough for LOW_CYC
   localparam int IDLE_W        = 15;               // wide enough for IDLE_CYC

   // ---------------------------------------------------------------
   // states and carriers
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE, S_RX, S_ACKW, S_ACK, S_LOAD, S_TX, S_MACK
   } smbrc_state_t;

   typedef enum logic [1:0] {
      PH_ADDR, PH_PTR, PH_DATA
   } smbrc_phase_t;

   typedef struct packed {
      logic [7:0] addr;                             // register pointer presented
      logic [7:0] wdata;                            // byte to store
      logic       wr;                               // one-cycle store strobe
      logic       rd;                               // one-cycle fetch strobe
   } smbrc_reg_req_t;

endpackage

`default_nettype wire

// file: src/smbrc_sync.sv
// smbrc_sync: three-stage synchroniser for a vector of foreign levels
// assumes the caller filters on agreement of the second and third stages
`timescale 1ns/1ps
`default_nettype none

module smbrc_sync (
   input  wire logic       clk_i,
   input  wire logic [2:0] d_i,
   output var  logic [2:0] s2_o,
   output var  logic [2:0] s3_o
);

   // ---------------------------------------------------------------
   // stage registers
   // ---------------------------------------------------------------
   logic [2:0] s1;                                  // metastable stage, read by s2 only
   logic [2:0] next_s1;
   logic [2:0] next_s2;
   logic [2:0] next_s3;

   // plain shift along the chain
   always_comb begin
      next_s1 = d_i;
      next_s2 = s1;
      next_s3 = s2_o;
   end

   // no reset: pure data path, flushed while the caller holds reset
   always_ff @(posedge clk_i) begin
      s1   <= next_s1;
      s2_o <= next_s2;
      s3_o <= next_s3;
   end

endmodule // smbrc_sync

`default_nettype wire

// file: testbench/smbrc_host_model.sv
// smbrc_host_model: behavioural smbus host driving clock and data
// assumes a pull-up on the data line, resolved by the bench
`timescale 1ns/1ps
`default_nettype none
module smbrc_host_model (
   output var  logic scl_o,
   output var  logic sda_low_o,
   input  wire logic sda_i
);
   // ---------------------------------------------------------------
   // link time base: 12 ns ticks, 70 ticks a half
   // ---------------------------------------------------------------
   localparam int HALF = 70;             // period 3 halves, about 397 kHz
   logic          lclk;                  // free tick, only paces the host
   initial begin
      lclk      = 1'b0;
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
      forever #6 lclk = ~lclk;
   end
   task automatic hold();
      repeat (HALF) @(posedge lclk);
   endtask
   // start, also repeated: data falls while clock high
   task automatic start();
      sda_low_o = 1'b0;
      hold();
      scl_o = 1'b1;
      hold();
      sda_low_o = 1'b1;
      hold();
      scl_o = 1'b0;
      hold();
   endtask
   // data only changes with the clock low, held a half after the fall
   task automatic bitx(input logic b, output logic r);
      sda_low_o = ~b;
      hold();
      scl_o = 1'b1;
      hold();
      r     = sda_i;
      scl_o = 1'b0;
      hold();
   endtask
   // msb first, ninth clock samples the client ack
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ack = ~r;
   endtask
   // host acks all but the last byte it reads
   task automatic rbyte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(~ack, r);
   endtask
   // park the clock at a level with data released, for the time-out cases
   task automatic park(input logic c);
      sda_low_o = 1'b0;
      scl_o     = c;
      hold();
   endtask
   // stop: data rises while clock high
   task automatic stop();
      sda_low_o = 1'b1;
      hold();
      scl_o = 1'b1;
      hold();
      sda_low_o = 1'b0;
      hold();
   endtask
endmodule // smbrc_host_model
`default_nettype wire

// file: testbench/testbench.sv
// testbench: runs host transfers against the client and a register array
// assumes the host model paces the link and time-outs start disabled
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [7:0] AW = {smbrc_pkg::CLIENT_ADDR, smbrc_pkg::RW_WRITE};
   localparam logic [7:0] AR = {smbrc_pkg::CLIENT_ADDR, smbrc_pkg::RW_READ};
   logic                      clk, rst_n, host_low, dut_oe, dut_o, sda_line, scl, ack;
   logic [7:0]                d;
   logic [7:0]                mem [256];   // register file model
   int                        fails, cmp_count;
   logic                      to_dis, sleep, busy;
   int                        rd_count;    // fetch pulses seen since reset
   smbrc_pkg::smbrc_reg_req_t req;
   assign sda_line = !(host_low || (dut_oe && !dut_o));   // open drain, pull-up
   smbrc_host_model smbrc_host_model_inst (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda_line));
   smbrc_client #(.LOW_CYC(400), .IDLE_CYC(200)) smbrc_client_inst (.clk_i(clk), .rst_n_i(rst_n),
      .bus_clock_line_i(scl), .sda_i(sda_line), .sda_o(dut_o), .sda_oe_o(dut_oe),
      .timeout_disable_i(to_dis), .sleep_i(sleep), .reg_rdata_i(mem[req.addr]), .reg_req_o(req), .busy_o(busy));
   always @(posedge clk) if (req.wr) mem[req.addr] <= req.wdata;
   always @(posedge clk) rd_count <= rst_n ? rd_count + int'(req.rd) : 0;
   task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic complete_run();
      if (fails == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic wb(input logic [7:0] v, input logic e, input string nm);
      smbrc_host_model_inst.wbyte(v, ack);
      check(nm, 8'(ack), 8'(e));
   endtask
   task automatic point(input logic [7:0] p);
      smbrc_host_model_inst.start();
      wb(AW, 1'b1, "addr ack");
      wb(p, 1'b1, "ptr ack");
   endtask
   task automatic rd(input logic a, input logic [7:0] e);
      smbrc_host_model_inst.rbyte(a, d);
      check("read data", d, e);
   endtask
   task automatic t_write_byte();
      point(8'h20);
      wb(8'hA5, 1'b1, "data ack");
      smbrc_host_model_inst.stop();
      check("reg 20", mem[8'h20], 8'hA5);
      check("busy stop", 8'(busy), 8'h00);
   endtask
   task automatic t_block_write();
      point(8'hFE);
      wb(8'h11, 1'b1, "blk ack");
      wb(8'h22, 1'b1, "blk ack");
      wb(8'h33, 1'b1, "blk ack");
      smbrc_host_model_inst.stop();
      check("reg ff", mem[8'hFF], 8'h22);
      check("reg 00", mem[8'h00], 8'h33);
   endtask
   task automatic t_reads();
      point(8'h20);
      smbrc_host_model_inst.start();
      wb(AR, 1'b1, "raddr ack");
      rd(1'b0, 8'hA5);
      smbrc_host_model_inst.stop();
      point(8'hFE);
      smbrc_host_model_inst.start();
      wb(AR, 1'b1, "raddr ack");
      rd(1'b1, 8'h11);
      rd(1'b1, 8'h22);
      rd(1'b0, 8'h33);
      smbrc_host_model_inst.stop();
      check("fetches", 8'(rd_count), 8'h04);
   endtask
   // foreign address, then a repeated pointer-only frame
   task automatic t_refusals();
      smbrc_host_model_inst.start();
      wb(8'hAC, 1'b0, "foreign ack");
      wb(8'h30, 1'b0, "foreign ptr");
      wb(8'hEE, 1'b0, "foreign dat");
      smbrc_host_model_inst.stop();
      check("reg 30", mem[8'h30], 8'h6A);
      point(8'h40);
      smbrc_host_model_inst.stop();
      smbrc_host_model_inst.start();
      wb(AW, 1'b1, "addr ack");
      wb(8'h41, 1'b0, "second send");
      smbrc_host_model_inst.stop();
      smbrc_host_model_inst.start();
      wb(AR, 1'b1, "raddr ack");
      rd(1'b0, 8'h1A);
      smbrc_host_model_inst.stop();
   endtask
   // let the link rest for n cycles, then look at the busy flag
   task automatic idle_for(input int n, input logic e, input string nm);
      repeat (n) @(negedge clk);
      check(nm, 8'(busy), 8'(e));
   endtask
   // time-outs: held off, clock-low expiry, idle expiry gated by sleep, restart
   task automatic t_timeouts();
      smbrc_host_model_inst.start();
      wb(AW, 1'b1, "addr ack");
      idle_for(600, 1'b1, "busy to off");
      wb(8'h50, 1'b1, "ptr kept");
      @(negedge clk) to_dis = 1'b0;
      idle_for(600, 1'b0, "busy low to");
      wb(8'h77, 1'b0, "dead ack");
      smbrc_host_model_inst.stop();
      check("reg 50", mem[8'h50], 8'h0A);
      for (int s = 1; s >= 0; s--) begin
         @(negedge clk) sleep = s[0];
         smbrc_host_model_inst.start();
         wb(AW, 1'b1, "addr ack");
         smbrc_host_model_inst.park(1'b1);
         idle_for(400, s[0], "busy idle");
         smbrc_host_model_inst.park(1'b0);
         smbrc_host_model_inst.stop();
      end
      point(8'h50);
      wb(8'h77, 1'b1, "data ack");
      smbrc_host_model_inst.stop();
      check("reg 50 new", mem[8'h50], 8'h77);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // watchdog: a hung run counts as a mismatch
   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      complete_run();
   end
   initial begin
      rst_n = 1'b0;
      to_dis = 1'b1;
      sleep = 1'b0;
      fails = 0;
      cmp_count = 0;
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;   // known contents
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (8) @(negedge clk);
      t_write_byte();
      t_block_write();
      t_reads();
      t_refusals();
      t_timeouts();
      complete_run();
   end
endmodule // testbench
`default_nettype wire
